// File: hw/uartr_top.sv
// Purpose: Serial transceiver with AHB-Lite registers and pin routing
// Assumes: Pins arrive unsynchronised, lines idle high, one stop bit
// Notes: Data phase always takes one wait state, response always OKAY
`timescale 1ns/1ps
module uartr_top
  import uartr_pkg::*;
#(
  parameter int CLK_HZ = CLK_RATE_HZ
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] pin_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic irq
);
  typedef enum logic [2:0] {
    UARTR_IDLE, UARTR_START, UARTR_DATA, UARTR_PAR, UARTR_STOP
  } uartr_bit_t;

  // Rate code to baud; unknown codes fall back to 250 kbaud
  function automatic int uartr_rate(input logic [31:0] code);
    case (code)
      32'h0004f000: uartr_rate = 1200;
      32'h0009d000: uartr_rate = 2400;
      32'h0013b000: uartr_rate = 4800;
      32'h00275000: uartr_rate = 9600;
      32'h003b0000: uartr_rate = 14400;
      32'h004ea000: uartr_rate = 19200;
      32'h0075f000: uartr_rate = 28800;
      32'h009d5000: uartr_rate = 38400;
      32'h00ebf000: uartr_rate = 57600;
      32'h013a9000: uartr_rate = 76800;
      32'h01d7e000: uartr_rate = 115200;
      32'h03afb000: uartr_rate = 230400;
      32'h04000000: uartr_rate = 250000;
      32'h075f7000: uartr_rate = 460800;
      32'h0ebedfa4: uartr_rate = 921600;
      32'h10000000: uartr_rate = 1000000;
      default: uartr_rate = 250000;
    endcase
  endfunction

  // Selected pin value, or idle level when not routed
  function automatic logic uartr_pick(input logic [31:0] sel,
                                      input logic [31:0] pins,
                                      input logic idle);
    if (sel[31:5] != 27'h0) begin
      uartr_pick = idle;
    end else begin
      uartr_pick = pins[sel[4:0]];
    end
  endfunction

  logic dph_r, wr_r, wr_en, rd_en;
  logic [11:0] addr_r;
  logic [31:0] rd_nxt;
  logic [3:0] enable_r, config_r, err_r, err_set;
  logic [31:0] psel_r [4];
  logic [31:0] baud_r, inten_r, evt_r, evt_set;
  logic [31:0] pin_s1_r, pin_s2_r;
  logic [17:0] div_r;
  logic uart_on, par_on, flow_on, rxd_line, cts_line, cts_ok;
  logic [21:0] frame_cyc;
  logic [23:0] to_load;
  logic [7:0] tx_buf_r, tx_sh_r;
  logic tx_pend_r, tx_run_r, txd_r, tx_par_r, tx_go;
  uartr_bit_t tx_st_r, rx_st_r;
  logic [17:0] tx_cnt_r, rx_cnt_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic rx_on_r, rx_stop_r, rx_par_r, rx_push, rx_pop, rts_hold_r;
  logic [7:0] rx_sh_r, rxd_r;
  logic rxd_valid_r, rx_read, rxd_prev_r;
  logic [23:0] to_cnt_r;
  logic [21:0] low_cnt_r;
  logic [7:0] rxq_mem [RXQ_DEPTH];
  logic [2:0] rxq_wp_r, rxq_rp_r, rxq_cnt_r;

  // Address phase taken on hready; one wait state in the data phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dph_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_r <= hsel && htrans[1] && hready;
      hreadyout <= !(hsel && htrans[1] && hready);
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_r <= hwrite;
        addr_r <= haddr[11:0];
      end
    end
  end
  assign wr_en = dph_r && wr_r;
  assign rd_en = dph_r && !wr_r;
  assign rx_read = rd_en && addr_r == OFF_RX_BYTE;

  // Read mux; unmapped and write-only locations read zero
  always_comb begin
    rd_nxt = 32'h0;
    if (addr_r == OFF_EV_RXBYTE) begin
      rd_nxt = {31'h0, evt_r[EVB_RXBYTE]};
    end else if (addr_r == OFF_EV_TXSENT) begin
      rd_nxt = {31'h0, evt_r[EVB_TXSENT]};
    end else if (addr_r == OFF_EV_ERROR) begin
      rd_nxt = {31'h0, evt_r[EVB_ERROR]};
    end else if (addr_r == OFF_EV_RECEIVE_TIMEOUT_EVENT) begin
      rd_nxt = {31'h0, evt_r[EVB_RECEIVE_TIMEOUT_EVENT]};
    end else if (addr_r == OFF_IRQ_SET || addr_r == OFF_IRQ_CLR) begin
      rd_nxt = inten_r;
    end else if (addr_r == OFF_ERR_CAUSE) begin
      rd_nxt = {28'h0, err_r};
    end else if (addr_r == OFF_ENABLE) begin
      rd_nxt = {28'h0, enable_r};
    end else if (addr_r == OFF_PSEL_RTS) begin
      rd_nxt = psel_r[0];
    end else if (addr_r == OFF_PSEL_TXD) begin
      rd_nxt = psel_r[1];
    end else if (addr_r == OFF_PSEL_CTS) begin
      rd_nxt = psel_r[2];
    end else if (addr_r == OFF_PSEL_RXD) begin
      rd_nxt = psel_r[3];
    end else if (addr_r == OFF_RX_BYTE) begin
      rd_nxt = {24'h0, rxd_r};
    end else if (addr_r == OFF_BAUD) begin
      rd_nxt = baud_r;
    end else if (addr_r == OFF_CONFIG) begin
      rd_nxt = {28'h0, config_r};
    end
  end

  // Read data held until the next read completes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (rd_en) begin
      hrdata <= rd_nxt;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable_r <= ENABLE_RST;
      config_r <= CONFIG_RST;
      baud_r <= BAUD_RST;
      for (int i = 0; i < 4; i++) begin
        psel_r[i] <= PSEL_NONE;
      end
    end else if (wr_en) begin
      if (addr_r == OFF_ENABLE) begin
        enable_r <= hwdata[3:0];
      end else if (addr_r == OFF_CONFIG) begin
        config_r <= hwdata[3:0];
      end else if (addr_r == OFF_BAUD) begin
        baud_r <= hwdata;
      end else if (addr_r == OFF_PSEL_RTS) begin
        psel_r[0] <= hwdata;
      end else if (addr_r == OFF_PSEL_TXD) begin
        psel_r[1] <= hwdata;
      end else if (addr_r == OFF_PSEL_CTS) begin
        psel_r[2] <= hwdata;
      end else if (addr_r == OFF_PSEL_RXD) begin
        psel_r[3] <= hwdata;
      end
    end
  end
  assign uart_on = enable_r == ENABLE_ON;
  assign par_on = config_r[3:1] == PARITY_ON;
  assign flow_on = config_r[CFG_FLOW];

  // Bit period from the rate table, registered to keep the divide off paths
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_r <= 18'(CLK_HZ / 250000);
    end else begin
      div_r <= 18'(CLK_HZ / uartr_rate(baud_r));
    end
  end
  assign frame_cyc = 22'(div_r * (par_on ? FRAME_BITS_PAR :
                                  FRAME_BITS_PLAIN));
  assign to_load = 24'(frame_cyc * STOP_BYTE_TIMES);

  // Two-flop synchroniser for every pin before routing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 32'hffffffff;
      pin_s2_r <= 32'hffffffff;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end
  // Unrouted CTS reads active so sending is never blocked by it
  assign rxd_line = uartr_pick(psel_r[3], pin_s2_r, 1'b1);
  assign cts_line = uartr_pick(psel_r[2], pin_s2_r, 1'b0);
  assign cts_ok = !flow_on || !cts_line;

  // Output routing; RTS is active low and idles high
  generate
    for (genvar g = 0; g < 32; g++) begin : g_pin
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pin_out[g] <= 1'b1;
          pin_oe[g] <= 1'b0;
        end else if (uart_on && psel_r[1] == 32'(g)) begin
          pin_out[g] <= txd_r;
          pin_oe[g] <= 1'b1;
        end else if (uart_on && psel_r[0] == 32'(g)) begin
          pin_out[g] <= !(rx_on_r && (!flow_on || !rts_hold_r));
          pin_oe[g] <= 1'b1;
        end else begin
          pin_out[g] <= 1'b1;
          pin_oe[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Transmitter: a new frame starts only on a byte boundary
  assign tx_go = uart_on && tx_run_r && tx_pend_r && cts_ok &&
                 tx_st_r == UARTR_IDLE;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_run_r <= 1'b0;
      tx_pend_r <= 1'b0;
      tx_buf_r <= 8'h00;
    end else begin
      if (wr_en && addr_r == OFF_TX_START) begin
        tx_run_r <= 1'b1;
      end else if (wr_en && addr_r == OFF_TX_STOP) begin
        tx_run_r <= 1'b0;
      end
      if (wr_en && addr_r == OFF_TX_BYTE) begin
        tx_buf_r <= hwdata[7:0];
        tx_pend_r <= 1'b1;
      end else if (tx_go || (wr_en && addr_r == OFF_TX_STOP)) begin
        tx_pend_r <= 1'b0;
      end
    end
  end

  // Transmit shifter; stop task aborts the frame at once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_st_r <= UARTR_IDLE;
      tx_cnt_r <= 18'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (!uart_on || (wr_en && addr_r == OFF_TX_STOP)) begin
      tx_st_r <= UARTR_IDLE;
      txd_r <= 1'b1;
    end else if (tx_go) begin
      tx_st_r <= UARTR_START;
      tx_sh_r <= tx_buf_r;
      tx_par_r <= ^tx_buf_r; // Even parity
      tx_cnt_r <= div_r - 18'h1;
      txd_r <= 1'b0;
    end else if (tx_st_r != UARTR_IDLE && tx_cnt_r != 18'h0) begin
      tx_cnt_r <= tx_cnt_r - 18'h1;
    end else begin
      tx_cnt_r <= div_r - 18'h1;
      case (tx_st_r)
        UARTR_START: begin
          tx_st_r <= UARTR_DATA;
          tx_bit_r <= 3'h0;
          txd_r <= tx_sh_r[0];
        end
        UARTR_DATA: begin
          tx_bit_r <= tx_bit_r + 3'h1;
          if (tx_bit_r == 3'h7) begin
            tx_st_r <= par_on ? UARTR_PAR : UARTR_STOP;
            txd_r <= par_on ? tx_par_r : 1'b1;
          end else begin
            txd_r <= tx_sh_r[tx_bit_r + 3'h1];
          end
        end
        UARTR_PAR: begin
          tx_st_r <= UARTR_STOP;
          txd_r <= 1'b1;
        end
        default: begin
          tx_st_r <= UARTR_IDLE;
          txd_r <= 1'b1;
        end
      endcase
    end
  end

  // Receiver run state and post-stop window of four byte-times
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_on_r <= 1'b0;
      rx_stop_r <= 1'b0;
      to_cnt_r <= 24'h0;
    end else if (wr_en && addr_r == OFF_RX_START) begin
      rx_on_r <= 1'b1;
      rx_stop_r <= 1'b0;
    end else if (wr_en && addr_r == OFF_RX_STOP) begin
      rx_on_r <= 1'b0;
      rx_stop_r <= 1'b1;
      to_cnt_r <= to_load;
    end else if (rx_stop_r) begin
      to_cnt_r <= to_cnt_r - 24'h1;
      if (to_cnt_r == 24'h0) begin
        rx_stop_r <= 1'b0;
      end
    end
  end

  // Last receive line level; resets to idle high so no false edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= rxd_line;
    end
  end

  // Receive shifter, sampled mid-bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_st_r <= UARTR_IDLE;
      rx_cnt_r <= 18'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else if (!uart_on) begin
      rx_st_r <= UARTR_IDLE;
    end else if (rx_st_r == UARTR_IDLE) begin
      // Falling edge only, so a long low after a bad frame is no start
      if (rxd_prev_r && !rxd_line && (rx_on_r || rx_stop_r)) begin
        rx_st_r <= UARTR_START;
        rx_cnt_r <= div_r >> 1;
      end
    end else if (rx_cnt_r != 18'h0) begin
      rx_cnt_r <= rx_cnt_r - 18'h1;
    end else begin
      rx_cnt_r <= div_r - 18'h1;
      case (rx_st_r)
        UARTR_START: begin
          rx_st_r <= rxd_line ? UARTR_IDLE : UARTR_DATA;
          rx_bit_r <= 3'h0;
        end
        UARTR_DATA: begin
          rx_sh_r <= {rxd_line, rx_sh_r[7:1]}; // LSB first
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == 3'h7) begin
            rx_st_r <= par_on ? UARTR_PAR : UARTR_STOP;
          end
        end
        UARTR_PAR: begin
          rx_par_r <= rxd_line;
          rx_st_r <= UARTR_STOP;
        end
        default: begin
          rx_st_r <= UARTR_IDLE;
        end
      endcase
    end
  end
  // Byte complete at the stop-bit sample, kept even when flawed
  assign rx_push = uart_on && rx_st_r == UARTR_STOP && rx_cnt_r == 18'h0;
  assign rx_pop = !rxd_valid_r && rxq_cnt_r != 3'h0;

  // Six-deep receive queue feeding the receive byte register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxq_wp_r <= 3'h0;
      rxq_rp_r <= 3'h0;
      rxq_cnt_r <= 3'h0;
      rxd_r <= 8'h00;
      rxd_valid_r <= 1'b0;
    end else begin
      if (rx_push && rxq_cnt_r != 3'(RXQ_DEPTH)) begin
        rxq_wp_r <= (rxq_wp_r == 3'(RXQ_DEPTH - 1)) ? 3'h0 :
                    rxq_wp_r + 3'h1;
      end
      if (rx_pop) begin
        rxd_r <= rxq_mem[rxq_rp_r];
        rxq_rp_r <= (rxq_rp_r == 3'(RXQ_DEPTH - 1)) ? 3'h0 :
                    rxq_rp_r + 3'h1;
      end
      rxq_cnt_r <= rxq_cnt_r
                 + 3'(rx_push && rxq_cnt_r != 3'(RXQ_DEPTH))
                 - 3'(rx_pop);
      if (rx_pop) begin
        rxd_valid_r <= 1'b1;
      end else if (rx_read) begin
        rxd_valid_r <= 1'b0;
      end
    end
  end

  // Queue storage carries no reset
  always_ff @(posedge clock) begin
    if (rx_push && rxq_cnt_r != 3'(RXQ_DEPTH)) begin
      rxq_mem[rxq_wp_r] <= rx_sh_r;
    end
  end

  // RTS drops at four free slots and returns only once all is read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rts_hold_r <= 1'b0;
    end else if (rxq_cnt_r >= 3'(RXQ_DEPTH - RXQ_ROOM_LOW)) begin
      rts_hold_r <= 1'b1;
    end else if (rxq_cnt_r == 3'h0 && !rxd_valid_r) begin
      rts_hold_r <= 1'b0;
    end
  end

  // Break: line low for longer than one whole frame, flagged once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_r <= 22'h0;
    end else if (!uart_on || rxd_line) begin
      low_cnt_r <= 22'h0;
    end else if (low_cnt_r <= frame_cyc) begin
      low_cnt_r <= low_cnt_r + 22'h1;
    end
  end

  // Error sources found this cycle
  always_comb begin
    err_set = 4'h0;
    err_set[ERB_OVERRUN] = rx_push && rxq_cnt_r == 3'(RXQ_DEPTH);
    err_set[ERB_PARITY] = rx_push && par_on &&
                          (rx_par_r != ^rx_sh_r);
    err_set[ERB_FRAMING] = rx_push && !rxd_line;
    err_set[ERB_BREAK] = uart_on && !rxd_line &&
                         low_cnt_r == frame_cyc;
  end

  // Error causes; a new cause beats a write-one clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_r <= 4'h0;
    end else if (wr_en && addr_r == OFF_ERR_CAUSE) begin
      err_r <= (err_r & ~hwdata[3:0]) | err_set;
    end else begin
      err_r <= err_r | err_set;
    end
  end

  // Event sources
  always_comb begin
    evt_set = 32'h0;
    evt_set[EVB_RXBYTE] = rx_pop;
    evt_set[EVB_TXSENT] = uart_on && tx_st_r == UARTR_STOP &&
                          tx_cnt_r == 18'h0;
    evt_set[EVB_ERROR] = |err_set;
    evt_set[EVB_RECEIVE_TIMEOUT_EVENT] = rx_stop_r && to_cnt_r == 24'h0 &&
                        !(wr_en && addr_r == OFF_RX_START);
  end

  // Sticky events, cleared by writing one; a new event wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt_r <= 32'h0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (evt_set[i]) begin
          evt_r[i] <= 1'b1;
        end else if (wr_en && hwdata[0] &&
                     ((i == EVB_RXBYTE && addr_r == OFF_EV_RXBYTE) ||
                      (i == EVB_TXSENT && addr_r == OFF_EV_TXSENT) ||
                      (i == EVB_ERROR && addr_r == OFF_EV_ERROR) ||
                      (i == EVB_RECEIVE_TIMEOUT_EVENT && addr_r == OFF_EV_RECEIVE_TIMEOUT_EVENT))) begin
          evt_r[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt enables through set and clear views, then the level irq
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inten_r <= 32'h0;
      irq <= 1'b0;
    end else begin
      if (wr_en && addr_r == OFF_IRQ_SET) begin
        inten_r <= inten_r | hwdata;
      end else if (wr_en && addr_r == OFF_IRQ_CLR) begin
        inten_r <= inten_r & ~hwdata;
      end
      irq <= |(evt_r & inten_r);
    end
  end
endmodule

// File: hw/uartr_pkg.sv
// Purpose: Shared constants for the serial transceiver register block
// Assumes: 32-bit AHB-Lite register bus, one clock domain
// Notes: Offsets are byte addresses within the block's 4 KiB window
package uartr_pkg;
  // Task, event and register offsets
  localparam logic [11:0] OFF_RX_START = 12'h000;
  localparam logic [11:0] OFF_RX_STOP = 12'h004;
  localparam logic [11:0] OFF_TX_START = 12'h008;
  localparam logic [11:0] OFF_TX_STOP = 12'h00c;
  localparam logic [11:0] OFF_EV_RXBYTE = 12'h108;
  localparam logic [11:0] OFF_EV_TXSENT = 12'h11c;
  localparam logic [11:0] OFF_EV_ERROR = 12'h124;
  localparam logic [11:0] OFF_EV_RECEIVE_TIMEOUT_EVENT = 12'h144;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [11:0] OFF_ERR_CAUSE = 12'h480;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_PSEL_RTS = 12'h508;
  localparam logic [11:0] OFF_PSEL_TXD = 12'h50c;
  localparam logic [11:0] OFF_PSEL_CTS = 12'h510;
  localparam logic [11:0] OFF_PSEL_RXD = 12'h514;
  localparam logic [11:0] OFF_RX_BYTE = 12'h518;
  localparam logic [11:0] OFF_TX_BYTE = 12'h51c;
  localparam logic [11:0] OFF_BAUD = 12'h524;
  localparam logic [11:0] OFF_CONFIG = 12'h56c;
  // Interrupt enable bit of each event
  localparam int EVB_RXBYTE = 2;
  localparam int EVB_TXSENT = 7;
  localparam int EVB_ERROR = 9;
  localparam int EVB_RECEIVE_TIMEOUT_EVENT = 17;
  // Error cause bits
  localparam int ERB_OVERRUN = 0;
  localparam int ERB_PARITY = 1;
  localparam int ERB_FRAMING = 2;
  localparam int ERB_BREAK = 3;
  // Field values and reset values
  localparam logic [3:0] ENABLE_ON = 4'h4;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [31:0] PSEL_NONE = 32'hffffffff;
  localparam logic [31:0] BAUD_RST = 32'h04000000;
  localparam logic [3:0] CONFIG_RST = 4'h0;
  localparam logic [2:0] PARITY_ON = 3'h7;
  localparam int CFG_FLOW = 0;
  // Receive queue and flow control figures
  localparam int RXQ_DEPTH = 6;
  localparam int RXQ_ROOM_LOW = 4;
  localparam int STOP_BYTE_TIMES = 4;
  localparam int FRAME_BITS_PLAIN = 10;
  localparam int FRAME_BITS_PAR = 11;
  localparam int CLK_RATE_HZ = 200_000_000;
endpackage

// File: bench/uartr_properties.sv
// Purpose: Bus and pin timing checks for the serial register block
// Assumes: Sees only the top ports, one clock domain
// Notes: TXP is the pin the bench routes the send line to
`timescale 1ns/1ps
module uartr_props #(
  parameter int CLK_HZ = 200_000_000,
  parameter int TXP = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Address phase accepted by the slave
  wire logic take = hsel && htrans[1] && hready;

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_wait_one: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("data phase not one wait state");
  a_idle_ready: assert property (!take |=> hreadyout)
    else $error("wait state without transfer");
  a_rdata_hold: assert property (
    $changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  // Interrupt only drops through a register write
  a_irq_cause: assert property ($fell(irq) |->
    !$past(hreadyout) || !$past(hreadyout, 2) || !$past(hreadyout, 3))
    else $error("interrupt dropped without a write");
  a_oe_cause: assert property ($changed(pin_oe) |->
    !$past(hreadyout) || !$past(hreadyout, 2) || !$past(hreadyout, 3))
    else $error("pin enables moved without a write");
  a_start_bit: assert property ($fell(pin_out[TXP]) && pin_oe[TXP] |->
    (!pin_out[TXP]) [*2])
    else $error("send line bit shorter than two clocks");
  a_oe_idle: assert property ($rose(pin_oe[TXP]) |-> pin_out[TXP])
    else $error("send line not idle when routed");
endmodule

// File: bench/uartr_remote.sv
// Purpose: Far-end serial port that captures our sends and sends back
// Assumes: Lines idle high, one stop bit, even parity when par is set
// Notes: A bad frame holds the line low past the frame to force a break
`timescale 1ns/1ps
module uartr_remote #(
  parameter int DIV = 8
) (
  input wire logic clock,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic par,
  output logic rxd,
  output logic [7:0] got,
  output logic got_par,
  output int got_n,
  output int late_n
);
  initial begin
    rxd = 1'b1;
    got_n = 0;
    late_n = 0;
  end
  // Capture frames, sampling mid-bit; parity read so it is not a start
  always begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clock);
      got[i] <= txd;
    end
    if (par) begin
      repeat (DIV) @(posedge clock);
      got_par <= txd;
    end
    repeat (DIV) @(posedge clock);
    got_n <= got_n + 1;
  end
  // Send one frame, start bit first and data LSB first
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    // Wait up to 4000 clocks for the request line to go active before a byte
    for (int w = 0; w < 4000 && rts_n; w++) @(posedge clock);
    // A wait that ran out is counted for the bench to report
    if (rts_n) late_n <= late_n + 1;
    for (int i = 0; i < 10 + par + (bad ? 3 : 0); i++) begin
      rxd <= (bad && i > 8) ? 1'b0 : ((i == 9 && !par) ? 1'b1 : f[i]);
      repeat (DIV) @(posedge clock);
    end
    rxd <= 1'b1;
    repeat (DIV) @(posedge clock);
  endtask
endmodule

// File: bench/tb.sv
// Purpose: Register-level tests of the serial block over AHB-Lite
// Assumes: CLK_HZ cut to 2 MHz so a bit is 8 clocks at reset rate
// Notes: Pins 1 send, 2 receive, 3 request, 4 clear-to-send
`timescale 1ns/1ps
module tb;
  import uartr_pkg::*;
  logic clock, rst, hsel, hwrite, cts_n, par, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, pin_in, pin_out, pin_oe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] got;
  logic got_par, rxd, txd, rts_n;
  int got_n, bad_count, check_count, late_n;
  // Released lines float high through pull-ups
  assign txd = pin_oe[1] ? pin_out[1] : 1'b1;
  assign rts_n = pin_oe[3] ? pin_out[3] : 1'b1;
  assign pin_in = {27'h7ffffff, cts_n, 1'b1, rxd, 2'h3};
  uartr_top #(.CLK_HZ(2_000_000)) u_dut (.clock(clock), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .pin_in(pin_in),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  uartr_remote #(.DIV(8)) u_rem (.clock(clock), .txd(txd), .rts_n(rts_n),
    .par(par), .rxd(rxd), .got(got), .got_par(got_par), .got_n(got_n),
    .late_n(late_n));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single transfer; a stuck bus ends the run
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clock); while (!hreadyout && ++n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (!hreadyout && ++n < 50);
    q = hrdata;
    if (n >= 50) begin
      chk("bus ready", 32'h0, 32'h1);
      finish_test();
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rc(logic [11:0] a, logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  // Poll an event flag under a bound
  task automatic wev(logic [11:0] a);
    logic [31:0] q;
    q = 32'h0;
    for (int i = 0; i < 300 && q[0] !== 1'b1; i++) xfer(1'b0, a, 32'h0, q);
    chk($sformatf("event %h", a), q, 32'h1);
    if (q[0] !== 1'b1) finish_test();
  endtask
  task automatic pause(int n);
    repeat (n) @(posedge clock);
  endtask
  logic [11:0] ra [12] = '{OFF_ENABLE, OFF_CONFIG, OFF_BAUD, OFF_PSEL_RTS,
    OFF_PSEL_TXD, OFF_PSEL_CTS, OFF_PSEL_RXD, OFF_ERR_CAUSE, OFF_RX_BYTE,
    OFF_IRQ_SET, OFF_TX_BYTE, 12'h600};
  logic [31:0] rv [12] = '{32'h0, 32'h0, BAUD_RST, PSEL_NONE, PSEL_NONE,
    PSEL_NONE, PSEL_NONE, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  initial begin
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, par, cts_n} = '0;
    hsize = 3'h2;
    pause(8);
    rst <= 1'b0;
    // Reset values, write-only and unmapped places read zero
    foreach (ra[i]) rc(ra[i], rv[i]);
    wr(12'h600, 32'hff);
    rc(12'h600, 32'h0);
    wr(OFF_BAUD, 32'h01d7e000);
    rc(OFF_BAUD, 32'h01d7e000);
    wr(OFF_BAUD, BAUD_RST);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_PSEL_RTS + 12'(4 * i), 32'(3 - 2 * (i % 2) + (i / 2)));
    end
    wr(OFF_ENABLE, 32'(ENABLE_ON));
    pause(3);
    chk("pin enables", pin_oe, 32'ha);
    $display("setup done");
    // Send with interrupt, mask and unmask, then clear
    wr(OFF_IRQ_SET, 32'h1 << EVB_TXSENT);
    rc(OFF_IRQ_CLR, 32'h80);
    wr(OFF_TX_START, 32'h1);
    wr(OFF_TX_BYTE, 32'h1a5);
    wev(OFF_EV_TXSENT);
    chk("sent byte", 32'(got), 32'ha5);
    chk("irq on", 32'(irq), 32'h1);
    wr(OFF_IRQ_CLR, 32'h80);
    pause(3);
    chk("irq masked", 32'(irq), 32'h0);
    wr(OFF_IRQ_SET, 32'h80);
    wr(OFF_EV_TXSENT, 32'h1);
    pause(3);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("send done");
    // Flow control holds the byte until clear-to-send, parity added
    wr(OFF_CONFIG, 32'hf);
    par <= 1'b1;
    cts_n <= 1'b1;
    wr(OFF_TX_BYTE, 32'h3c);
    pause(200);
    chk("held count", 32'(got_n), 32'h1);
    cts_n <= 1'b0;
    wev(OFF_EV_TXSENT);
    chk("flow byte", 32'(got), 32'h3c);
    chk("parity", 32'(got_par), 32'(^8'h3c));
    $display("flow done");
    // Receive, then a frame without stop bit that turns into a break
    wr(OFF_CONFIG, 32'h0);
    par <= 1'b0;
    wr(OFF_RX_START, 32'h1);
    u_rem.send(8'h5a, 1'b0);
    wev(OFF_EV_RXBYTE);
    rc(OFF_RX_BYTE, 32'h5a);
    u_rem.send(8'h00, 1'b1);
    wev(OFF_EV_ERROR);
    rc(OFF_ERR_CAUSE, 32'hc);
    wr(OFF_ERR_CAUSE, 32'hf);
    rc(OFF_ERR_CAUSE, 32'h0);
    rc(OFF_RX_BYTE, 32'h0);
    // Eight unread bytes: one in the register, six queued, one lost
    for (int i = 0; i < 8; i++) u_rem.send(8'(8'h10 + i), 1'b0);
    rc(OFF_ERR_CAUSE, 32'h1);
    rc(OFF_RX_BYTE, 32'h10);
    // Queue still holds five, so flow control must drop the request line
    wr(OFF_CONFIG, 32'h1);
    pause(2);
    chk("request held", 32'(rts_n), 32'h1);
    wr(OFF_CONFIG, 32'h0);
    pause(2);
    $display("receive done");
    // Stopping the receiver drops the request line, then times out
    chk("request on", 32'(rts_n), 32'h0);
    wr(OFF_RX_STOP, 32'h1);
    rc(OFF_EV_RECEIVE_TIMEOUT_EVENT, 32'h0);
    chk("request off", 32'(rts_n), 32'h1);
    wev(OFF_EV_RECEIVE_TIMEOUT_EVENT);
    wr(OFF_TX_STOP, 32'h1);
    wr(OFF_ENABLE, 32'h0);
    pause(3);
    chk("pins released", pin_oe, 32'h0);
    chk("remote stalls", 32'(late_n), 32'h0);
    $display("stop done");
    finish_test();
  end
endmodule
bind uartr_top uartr_props #(.CLK_HZ(CLK_HZ), .TXP(1)) u_props (
  .clock(clock), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
